// [pxp_pkg.sv]
// ****************************************************************
// Shared constants for the port expander and its bus controller.
// ****************************************************************
package pxp_pkg;

  // ****************************************************************
  // Device addressing and register selection.
  // ****************************************************************
  localparam logic [6:0] DEV_ADDR = 7'h41;
  localparam logic [1:0] PTR_IN   = 2'h0;
  localparam logic [1:0] PTR_OUT  = 2'h1;
  localparam logic [1:0] PTR_POL  = 2'h2;
  localparam logic [1:0] PTR_DIR  = 2'h3;
  localparam logic [7:0] PTR_RST  = 8'h00;

  // ****************************************************************
  // Register reset values and the unused upper nibble.
  // ****************************************************************
  localparam logic [7:0] OUT_RST    = 8'hFF;
  localparam logic [7:0] POL_RST    = 8'h00;
  localparam logic [7:0] DIR_RST    = 8'hFF;
  localparam logic [3:0] IN_UNUSED  = 4'hF;
  localparam int         PIN_W      = 4;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] LAST_TXBIT = 4'h7;

  // ****************************************************************
  // Link timing.
  // ****************************************************************
  localparam int CLK_NS         = 10;
  localparam int LINK_PERIOD_NS = 160;
  localparam int QTR_CYC        = LINK_PERIOD_NS / (4 * CLK_NS);

  // ****************************************************************
  // Controller register map and fields.
  // ****************************************************************
  localparam logic [31:0] OFS_CMD     = 32'h0000_0000;
  localparam logic [31:0] OFS_STAT    = 32'h0000_0004;
  localparam int          CMD_START   = 8;
  localparam int          CMD_STOP    = 9;
  localparam int          CMD_WR      = 10;
  localparam int          CMD_RD      = 11;
  localparam int          CMD_NACK    = 12;
  localparam int          CMD_W       = 13;
  localparam int          STAT_BUSY   = 0;
  localparam int          STAT_ACK    = 1;
  localparam int          STAT_RX_LSB = 8;

endpackage

// [pxp_link_if.sv]
`timescale 1ns/1ps
// ****************************************************************
// Two-wire link; both lines are open drain with pull-ups.
// ****************************************************************
interface pxp_link_if;
  logic scl_o;
  logic scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;

  assign scl = !(scl_oe && !scl_o);
  assign sda = !(m_sda_oe && !m_sda_o) && !(d_sda_oe && !d_sda_o);

  modport host (output scl_o, output scl_oe, output m_sda_o, output m_sda_oe, input scl, input sda);
  modport dev  (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface

// [pxp_dev.sv]
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - Command byte after address stored as pointer
// - Pointer low bits pick one of four
// - Command only first byte of write transfer
// - Pointer persists across reads until rewritten
// - Input register shows every pin level
// - Writes to input register are discarded
// - Input upper nibble reads ones
// - Output bit drives pin only when output
// - Output register reads stored latch value
// - Polarity bit inverts reported input level
// - Direction one input, zero driven output
// - Reset loads defaults and idles bus
// - Write: address, command, then data bytes
// - Any number of written data bytes
// - Pointed read uses repeated start, read address
// - Repeated start keeps register selection
// - Read data captured at acknowledge rising edge
// - Master nacks the final read byte
// - Direct read returns whichever register the pointer selects
// - Stop ends any transfer cleanly
// - Respond only to address sixty-five
// - Acknowledge every byte received as receiver

module pxp_dev (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Two-wire link
  pxp_link_if.dev          lk,
  // Port pins
  input  wire logic [3:0]  pin_in,
  output logic      [3:0]  pin_out,
  output logic      [3:0]  pin_oe
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_RX   = 3'b001,
    DS_ACK  = 3'b011,
    DS_TX   = 3'b010,
    DS_MACK = 3'b110
  } pxp_dst_e;

  typedef struct packed {
    pxp_dst_e   st;
    logic [1:0] scl_m;
    logic [1:0] sda_m;
    logic       scl_d;
    logic       sda_d;
    logic [3:0] pin_m0;
    logic [3:0] pin_m1;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic       addr_ph;
    logic       cmd_ph;
    logic       rw;
    logic [7:0] ptr;
    logic [3:0] outp;
    logic [3:0] pol;
    logic [3:0] dir;
    logic [3:0] oe;
    logic       sda_oe;
  } pxp_dst_s;

  pxp_dst_s r;
  pxp_dst_s n;
  logic     scl;
  logic     sda;
  logic     rise;
  logic     fall;
  logic     start_c;
  logic     stop_c;

  // ****************************************************************
  // Register read mux.
  // ****************************************************************
  function automatic logic [7:0] rd_reg(input logic [1:0] p, input pxp_dst_s s);
    logic [7:0] v;
    v = 8'h00;
    unique case (p)
      pxp_pkg::PTR_IN:  v = {pxp_pkg::IN_UNUSED, s.pin_m1 ^ s.pol};
      pxp_pkg::PTR_OUT: v = {pxp_pkg::OUT_RST[7:4], s.outp};
      pxp_pkg::PTR_POL: v = {pxp_pkg::POL_RST[7:4], s.pol};
      pxp_pkg::PTR_DIR: v = {pxp_pkg::DIR_RST[7:4], s.dir};
    endcase
    return v;
  endfunction

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb begin
    n        = r;
    n.scl_m  = {r.scl_m[0], lk.scl};
    n.sda_m  = {r.sda_m[0], lk.sda};
    n.pin_m0 = pin_in;
    n.pin_m1 = r.pin_m0;
    scl      = r.scl_m[1];
    sda      = r.sda_m[1];
    n.scl_d  = scl;
    n.sda_d  = sda;
    rise     = scl & ~r.scl_d;
    fall     = ~scl & r.scl_d;
    start_c  = scl & r.scl_d & r.sda_d & ~sda;
    stop_c   = scl & r.scl_d & ~r.sda_d & sda;
    if (stop_c) begin
      n.st     = DS_IDLE;
      n.sda_oe = 1'b0;
    end else if (start_c) begin
      n.st      = DS_RX;
      n.cnt     = 4'h0;
      n.addr_ph = 1'b1;
      n.cmd_ph  = 1'b0;
      n.sda_oe  = 1'b0;
    end else begin
      unique case (r.st)
        DS_IDLE: begin
        end
        DS_RX: begin
          if (rise) begin
            n.sh  = {r.sh[6:0], sda};
            n.cnt = r.cnt + 4'h1;
          end else if (fall && r.cnt == pxp_pkg::BYTE_BITS) begin
            n.st     = DS_ACK;
            n.sda_oe = 1'b1;
            if (r.addr_ph) begin
              n.addr_ph = 1'b0;
              if (r.sh[7:1] == pxp_pkg::DEV_ADDR) begin
                n.rw     = r.sh[0];
                // command only follows a write address
                n.cmd_ph = ~r.sh[0];
              end else begin
                n.st     = DS_IDLE;
                n.sda_oe = 1'b0;
              end
            end else if (r.cmd_ph) begin
              // store whole byte, decode low bits
              n.ptr    = r.sh;
              n.cmd_ph = 1'b0;
            end else begin
              // every further byte lands in the pointed register, except the input register
              unique case (r.ptr[1:0])
                pxp_pkg::PTR_IN: begin
                end
                // only the low nibble is stored
                pxp_pkg::PTR_OUT: n.outp = r.sh[3:0];
                pxp_pkg::PTR_POL: n.pol = r.sh[3:0];
                pxp_pkg::PTR_DIR: begin
                  n.dir = r.sh[3:0];
                  // one makes an input, zero drives
                  n.oe  = ~r.sh[3:0];
                end
              endcase
            end
          end
        end
        DS_ACK: begin
          if (rise && r.rw) begin
            // capture selected register at ack rise
            n.sh = rd_reg(r.ptr[1:0], r);
          end else if (fall) begin
            n.cnt = 4'h0;
            if (r.rw) begin
              n.st     = DS_TX;
              n.sda_oe = ~r.sh[7];
            end else begin
              n.st     = DS_RX;
              n.sda_oe = 1'b0;
            end
          end
        end
        DS_TX: begin
          if (fall) begin
            n.cnt = r.cnt + 4'h1;
            if (r.cnt == pxp_pkg::LAST_TXBIT) begin
              n.st     = DS_MACK;
              n.sda_oe = 1'b0;
            end else begin
              n.sh     = {r.sh[6:0], 1'b0};
              n.sda_oe = ~r.sh[6];
            end
          end
        end
        DS_MACK: begin
          if (rise) begin
            // a nack from the master ends the read
            if (sda) begin
              n.st = DS_IDLE;
            end else begin
              // next byte captured at ack rise
              n.sh = rd_reg(r.ptr[1:0], r);
            end
          end else if (fall) begin
            n.st     = DS_TX;
            n.cnt    = 4'h0;
            n.sda_oe = ~r.sh[7];
          end
        end
        default: begin
          n.st     = DS_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r        <= '0;
      r.st     <= DS_IDLE;
      r.scl_m  <= 2'h3;
      r.sda_m  <= 2'h3;
      r.scl_d  <= 1'b1;
      r.sda_d  <= 1'b1;
      r.ptr    <= pxp_pkg::PTR_RST;
      r.outp   <= pxp_pkg::OUT_RST[3:0];
      r.pol    <= pxp_pkg::POL_RST[3:0];
      r.dir    <= pxp_pkg::DIR_RST[3:0];
      r.oe     <= ~pxp_pkg::DIR_RST[3:0];
    end else begin
      r <= n;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  // Pins are push-pull; the pad drives pin_out only where pin_oe is set.
  // pin_out carries the whole output latch, not gated by pin_oe
  assign pin_out     = r.outp;
  assign pin_oe      = r.oe;
  assign lk.d_sda_o  = 1'b0;
  assign lk.d_sda_oe = r.sda_oe;

endmodule

// [pxp_host.sv]
`timescale 1ns/1ps
// ****************************************************************
// Link master driven by byte commands from an AHB-Lite slave port.
// ****************************************************************
module pxp_host #(
  parameter int QTR_CYC = pxp_pkg::QTR_CYC
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Two-wire link
  pxp_link_if.host         lk
);

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_START = 2'b01,
    HS_BIT   = 2'b11,
    HS_STOP  = 2'b10
  } pxp_hst_e;

  typedef struct packed {
    pxp_hst_e    st;
    logic [7:0]  div;
    logic [1:0]  q;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  rx;
    logic [12:0] cmd;
    logic        ack;
    logic        ap_cmd;
    logic [1:0]  sda_m;
    logic        scl_oe;
    logic        sda_oe;
    logic [31:0] hrdata;
  } pxp_hst_s;

  pxp_hst_s r;
  pxp_hst_s n;
  logic     busy;
  logic     tick;
  logic     sda;

  always_comb begin
    n       = r;
    n.sda_m = {r.sda_m[0], lk.sda};
    sda     = r.sda_m[1];
    busy    = (r.st != HS_IDLE) | r.ap_cmd;
    tick    = (r.div == 8'(QTR_CYC - 1));
    n.div   = (tick || r.st == HS_IDLE) ? 8'h00 : r.div + 8'h01;
    // ****************************************************************
    // Bus port: zero wait states, read data registered in the address phase.
    // ****************************************************************
    n.ap_cmd = 1'b0;
    if (hsel && htrans[1] && hready) begin
      n.ap_cmd = hwrite && (haddr == pxp_pkg::OFS_CMD);
      n.hrdata = 32'h0000_0000;
      if (!hwrite && haddr == pxp_pkg::OFS_CMD) begin
        n.hrdata[pxp_pkg::CMD_W-1:0] = r.cmd;
      end else if (!hwrite && haddr == pxp_pkg::OFS_STAT) begin
        n.hrdata[pxp_pkg::STAT_BUSY]                         = busy;
        n.hrdata[pxp_pkg::STAT_ACK]                          = r.ack;
        n.hrdata[pxp_pkg::STAT_RX_LSB+7:pxp_pkg::STAT_RX_LSB] = r.rx;
      end
    end
    // A command written while a previous one runs is dropped.
    if (r.ap_cmd && r.st == HS_IDLE) begin
      n.cmd = hwdata[pxp_pkg::CMD_W-1:0];
      n.sh  = hwdata[7:0];
      n.q   = 2'h0;
      n.cnt = 4'h0;
      if (hwdata[pxp_pkg::CMD_START]) begin
        n.st = HS_START;
      end else if (hwdata[pxp_pkg::CMD_WR] || hwdata[pxp_pkg::CMD_RD]) begin
        n.st = HS_BIT;
      end else if (hwdata[pxp_pkg::CMD_STOP]) begin
        n.st = HS_STOP;
      end
    end else if (tick) begin
      // ****************************************************************
      // Bit engine, four quarter periods per link clock.
      // ****************************************************************
      n.q = r.q + 2'h1;
      unique case (r.st)
        HS_IDLE: begin
        end
        HS_START: begin
          unique case (r.q)
            2'h0: n.sda_oe = 1'b0;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b1;
            2'h3: begin
              n.scl_oe = 1'b1;
              if (r.cmd[pxp_pkg::CMD_WR] || r.cmd[pxp_pkg::CMD_RD]) begin
                n.st = HS_BIT;
              end else if (r.cmd[pxp_pkg::CMD_STOP]) begin
                n.st = HS_STOP;
              end else begin
                n.st = HS_IDLE;
              end
            end
          endcase
        end
        HS_BIT: begin
          unique case (r.q)
            2'h0: begin
              if (r.cnt == pxp_pkg::BYTE_BITS) begin
                n.sda_oe = r.cmd[pxp_pkg::CMD_RD] & ~r.cmd[pxp_pkg::CMD_NACK];
              end else begin
                n.sda_oe = r.cmd[pxp_pkg::CMD_WR] & ~r.sh[7];
              end
            end
            2'h1: n.scl_oe = 1'b0;
            2'h2: begin
              if (r.cnt == pxp_pkg::BYTE_BITS) begin
                n.ack = r.cmd[pxp_pkg::CMD_WR] ? ~sda : r.ack;
              end else begin
                n.sh = {r.sh[6:0], sda};
              end
            end
            2'h3: begin
              n.scl_oe = 1'b1;
              n.cnt    = r.cnt + 4'h1;
              if (r.cnt == pxp_pkg::BYTE_BITS) begin
                n.rx = r.cmd[pxp_pkg::CMD_RD] ? r.sh : r.rx;
                n.st = r.cmd[pxp_pkg::CMD_STOP] ? HS_STOP : HS_IDLE;
              end
            end
          endcase
        end
        HS_STOP: begin
          unique case (r.q)
            2'h0: n.sda_oe = 1'b1;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b0;
            2'h3: n.st = HS_IDLE;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r       <= '0;
      r.st    <= HS_IDLE;
      r.sda_m <= 2'h3;
    end else begin
      r <= n;
    end
  end

  // Only whole-word single transfers are used, so hsize is not decoded.
  assign hrdata      = r.hrdata;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign lk.scl_o    = 1'b0;
  assign lk.scl_oe   = r.scl_oe;
  assign lk.m_sda_o  = 1'b0;
  assign lk.m_sda_oe = r.sda_oe;

endmodule

// [pxp_assertions.sv]
`timescale 1ns/1ps
// ****************************************************************
// Link checker beside the joined host and device ends.
// ****************************************************************
module pxp_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link wires and device drive
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_oe
);
  logic       scl_q;
  logic       sda_q;
  logic       adr_r;
  logic       wr_r;
  logic       hit_r;
  logic [3:0] bc_r;
  logic [7:0] sh_r;
  logic       rise;
  logic       start;

  assign rise  = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;

  // ****************************************************************
  // Byte tracking.
  // ****************************************************************
  // The bit count restarts on every start, so a repeated start realigns it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      adr_r <= 1'b0;
      wr_r  <= 1'b0;
      hit_r <= 1'b0;
      bc_r  <= 4'h0;
      sh_r  <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        bc_r  <= 4'h0;
        adr_r <= 1'b1;
        hit_r <= 1'b0;
      end else if (rise && bc_r == 4'h8) begin
        bc_r  <= 4'h0;
        adr_r <= 1'b0;
        if (adr_r) begin
          wr_r  <= !sh_r[0];
          hit_r <= sh_r[7:1] == pxp_pkg::DEV_ADDR;
        end
      end else if (rise) begin
        bc_r <= bc_r + 4'h1;
        sh_r <= {sh_r[6:0], sda};
      end
    end
  end

  // ****************************************************************
  // Properties.
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  addr_ack_a: assert property (rise && bc_r == 4'h8 && adr_r && sh_r[7:1] == pxp_pkg::DEV_ADDR |-> d_sda_oe)
    else $error("Own address was not acknowledged.");
  addr_nak_a: assert property (rise && bc_r == 4'h8 && adr_r && sh_r[7:1] != pxp_pkg::DEV_ADDR |-> !d_sda_oe)
    else $error("Foreign address was acknowledged.");
  data_ack_a: assert property (rise && bc_r == 4'h8 && !adr_r && hit_r && wr_r |-> d_sda_oe)
    else $error("Written byte was not acknowledged.");
  read_free_a: assert property (rise && bc_r == 4'h8 && !adr_r && hit_r && !wr_r |-> !d_sda_oe)
    else $error("Device held data line in master ack slot.");
  idle_quiet_a: assert property (!adr_r && !hit_r |-> !d_sda_oe)
    else $error("Unaddressed device drove the data line.");
  start_quiet_a: assert property (start |=> !d_sda_oe [*8])
    else $error("Device drove the data line right after a start.");
  stop_free_a: assert property (scl && scl_q && !sda_q && sda |-> ##[1:8] !d_sda_oe)
    else $error("Device did not release the data line after a stop.");
  high_still_a: assert property ($rose(scl) |=> $stable(d_sda_oe) [*3])
    else $error("Device changed the data line while the clock was high.");
endmodule

// [i2c_four_bit_port_expander_regs_tb_top.sv]
`timescale 1ns/1ps
// ****************************************************************
// Host and device joined over the link, driven through AHB-Lite.
// ****************************************************************
module i2c_four_bit_port_expander_regs_tb_top;
  localparam logic [7:0] wr_adr = {pxp_pkg::DEV_ADDR, 1'b0};
  localparam logic [7:0] rd_adr = {pxp_pkg::DEV_ADDR, 1'b1};
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  pin_in;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe;
  int          bad_count;
  int          cmp_count;

  pxp_link_if i_pxp_link_if ();
  pxp_host #(.QTR_CYC(4)) i_pxp_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .lk(i_pxp_link_if.host));
  pxp_dev i_pxp_dev (.hclk(hclk), .hresetn(hresetn), .lk(i_pxp_link_if.dev), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe));
  pxp_assertions i_pxp_assertions (.hclk(hclk), .hresetn(hresetn), .scl(i_pxp_link_if.scl),
    .sda(i_pxp_link_if.sda), .d_sda_oe(i_pxp_link_if.d_sda_oe));

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Read data is taken before this edge's updates land, so it is the data-phase value.
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask

  task automatic go(input logic [31:0] c, output logic [31:0] st);
    do ahb(1'b0, pxp_pkg::OFS_STAT, 32'h0000_0000, st); while (st[pxp_pkg::STAT_BUSY] !== 1'b0);
    ahb(1'b1, pxp_pkg::OFS_CMD, c, st);
    do ahb(1'b0, pxp_pkg::OFS_STAT, 32'h0000_0000, st); while (st[pxp_pkg::STAT_BUSY] !== 1'b0);
  endtask

  task automatic wb(input logic s, input logic p, input logic [7:0] b, input logic ack);
    logic [31:0] st;
    go({19'h0_0000, 3'h1, p, s, b}, st);
    chk("ack", {31'h0000_0000, ack}, {31'h0000_0000, st[pxp_pkg::STAT_ACK]});
  endtask

  // The last byte is not acknowledged and is followed by a stop.
  task automatic rb(input logic last, input logic [7:0] exp, input string nm);
    logic [31:0] st;
    go({19'h0_0000, last, 2'h2, last, 1'b0, 8'h00}, st);
    chk(nm, {24'h00_0000, exp}, {24'h00_0000, st[15:8]});
  endtask

  task automatic setreg(input logic [7:0] c, input logic [7:0] d);
    wb(1'b1, 1'b0, wr_adr, 1'b1);
    wb(1'b0, 1'b0, c, 1'b1);
    wb(1'b0, 1'b1, d, 1'b1);
  endtask

  task automatic getreg(input logic [7:0] c, input logic [7:0] exp, input string nm);
    wb(1'b1, 1'b0, wr_adr, 1'b1);
    wb(1'b0, 1'b0, c, 1'b1);
    wb(1'b1, 1'b0, rd_adr, 1'b1);
    rb(1'b1, exp, nm);
  endtask

  task automatic pins(input logic [3:0] o, input logic [3:0] e);
    chk("pin_out", {28'h000_0000, o}, {28'h000_0000, pin_out});
    chk("pin_oe", {28'h000_0000, e}, {28'h000_0000, pin_oe});
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset();
    pins(4'hF, 4'h0);
    getreg(8'h01, 8'hFF, "out");
    getreg(8'h02, 8'h00, "pol");
    getreg(8'h03, 8'hFF, "dir");
    getreg(8'h00, 8'hFA, "in");
    $display("reset test done");
  endtask

  task automatic t_write();
    setreg(8'h03, 8'hA6);
    getreg(8'h03, 8'hF6, "dir");
    setreg(8'h01, 8'h05);
    getreg(8'h01, 8'hF5, "out");
    wb(1'b1, 1'b0, wr_adr, 1'b1);
    wb(1'b0, 1'b0, 8'h01, 1'b1);
    wb(1'b0, 1'b0, 8'h03, 1'b1);
    wb(1'b0, 1'b1, 8'h0C, 1'b1);
    pins(4'hC, 4'h9);
    getreg(8'h00, 8'hFA, "in");
    $display("write test done");
  endtask

  task automatic t_pol();
    setreg(8'h02, 8'h03);
    getreg(8'h00, 8'hF9, "in");
    wb(1'b1, 1'b0, rd_adr, 1'b1);
    rb(1'b0, 8'hF9, "in");
    rb(1'b1, 8'hF9, "in");
    pin_in <= 4'h5;
    wb(1'b1, 1'b0, rd_adr, 1'b1);
    rb(1'b1, 8'hF6, "in");
    $display("polarity test done");
  endtask

  task automatic t_discard();
    setreg(8'h00, 8'h55);
    getreg(8'h01, 8'hFC, "out");
    getreg(8'h02, 8'h03, "pol");
    getreg(8'h03, 8'hF6, "dir");
    pins(4'hC, 4'h9);
    setreg(8'hFD, 8'h09);
    pins(4'h9, 4'h9);
    getreg(8'hE1, 8'hF9, "out");
    $display("discard test done");
  endtask

  task automatic t_link();
    logic [7:0] bad [3];
    bad = '{8'h80, 8'h84, 8'hC2};
    foreach (bad[i]) wb(1'b1, 1'b1, bad[i], 1'b0);
    wb(1'b1, 1'b1, wr_adr, 1'b1);
    wb(1'b1, 1'b0, wr_adr, 1'b1);
    wb(1'b0, 1'b1, 8'h02, 1'b1);
    wb(1'b1, 1'b0, rd_adr, 1'b1);
    rb(1'b1, 8'h03, "pol");
    $display("link test done");
  endtask

  // ****************************************************************
  // Run control.
  // ****************************************************************
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial begin
    hresetn   = 1'b0;
    hsel      = 1'b0;
    haddr     = 32'h0000_0000;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hwdata    = 32'h0000_0000;
    pin_in    = 4'hA;
    bad_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    t_reset();
    t_write();
    t_pol();
    t_discard();
    t_link();
    stop_test();
  end

  // About eighty link bytes with polling stay well inside this span.
  initial begin
    #500_000;
    bad_count++;
    stop_test();
  end
endmodule
